// file: common/gpr_pkg.sv
// gpio port register block constants
package gpr_pkg;
  localparam logic [7:0] ADDR_PORT_ZERO_LATCH      = 8'h80;
  localparam logic [7:0] ADDR_PORT_ONE_LATCH       = 8'h90;
  localparam logic [7:0] ADDR_DATA_PAGE_SELECT     = 8'hA0;
  localparam logic [7:0] ADDR_PORT_ZERO_DRIVE_TYPE = 8'hA4;
  localparam logic [7:0] ADDR_PORT_ONE_DRIVE_TYPE  = 8'hA5;
  localparam logic [7:0] RST_PORT_ZERO_LATCH       = 8'hDF;
  localparam logic [1:0] RST_PORT_ONE_LATCH        = 2'h3;
  localparam logic [7:0] RST_DATA_PAGE_SELECT      = 8'h00;
  localparam logic [7:0] RST_PORT_ZERO_DRIVE_TYPE  = 8'h00;
  localparam logic [1:0] RST_PORT_ONE_DRIVE_TYPE   = 2'h0;
  localparam int         INPUT_ONLY_BIT            = 0;
  localparam int         LED_BIT                   = 5;
  localparam logic [1:0] LED_LEVEL_OFF             = 2'h0;
  localparam int         PORT_ONE_WIDTH            = 2;
endpackage

// file: hw/gpr_port_regs.sv
// gpio port data, drive type and data page registers
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// RULE_01: port zero writes drive pin outputs; reads return live pin levels.
// RULE_02: written 0 pulls low; 1 releases open-drain or drives high push-pull.
// RULE_03: pin 0 is input only; its data bit drives nothing.
// RULE_04: pin 5 data bit switches the LED current when a level is selected.
// RULE_05: pin 5 reads intended LED state; 0 when the current level is zero.
// RULE_06: pin 5 readback ignores debug forcing of the LED driver off.
// RULE_07: port zero drive type bit: 0 open-drain, 1 push-pull.
// RULE_08: software makes an input by choosing open-drain and writing 1.
// RULE_09: port one data has only bits 1:0, pins 8 and 9; rest read 0.
// RULE_10: port one drive type: 0 open-drain with pull-up, 1 push-pull.
// RULE_11: port one drive type has only bits 1:0; upper bits read 0.
// RULE_12: data page select drives no pins; plain 8-bit storage.
// RULE_13: data page select gives the upper address byte for paged accesses.
// RULE_14: port data registers support single bit set, clear and test.
// RULE_15: LED level 00 gives no current; 01 to 11 increase it.
// RULE_16: pin inputs pass a two-stage synchroniser before readback.
module gpr_port_regs (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrEn,
  input  wire logic [7:0] regWrData,
  input  wire logic       bitWrEn,
  input  wire logic [2:0] bitSel,
  input  wire logic       bitVal,
  output logic      [7:0] regRdData,
  output logic            bitRdData,
  input  wire logic [1:0] ledCurrentLevel,
  input  wire logic       ledDebugOff,
  input  wire logic [7:0] portZeroPinIn,
  output logic      [7:0] portZeroPinOut,
  output logic      [7:0] portZeroPinOe,
  input  wire logic [1:0] portOnePinIn,
  output logic      [1:0] portOnePinOut,
  output logic      [1:0] portOnePinOe,
  output logic      [1:0] portOnePullUpEn,
  output logic            ledDriveEn,
  output logic      [1:0] ledDriveLevel,
  output logic      [7:0] pagedDataPage
);

  // cpu-visible register state
  logic [7:0] portZeroLatch_r;
  logic [1:0] portOneLatch_r;
  logic [7:0] dataPageSelect_r;
  logic [7:0] portZeroDriveType_r;
  logic [1:0] portOneDriveType_r;

  // pin synchroniser stages, meta flop then sync flop
  logic [7:0] zeroMeta_r;
  logic [7:0] zeroSync_r;
  logic [1:0] oneMeta_r;
  logic [1:0] oneSync_r;

  // read path helpers
  logic [7:0] zeroReadback;
  logic [7:0] oneReadback;
  logic [7:0] zeroTypeRd;
  logic [7:0] oneTypeRd;

  // write path helpers and per-register write strobes
  logic [7:0] zeroWrNxt;
  logic [7:0] oneWrNxt;
  logic       zeroLatchWrEn;
  logic       oneLatchWrEn;
  logic       pageWrEn;
  logic       zeroTypeWrEn;
  logic       oneTypeWrEn;

  // led control
  logic       ledLevelOn;
  logic       ledIntended;

  // pad slices built by the generate loops below
  wire logic [7:0] zeroPadOe;
  wire logic [7:0] zeroPadOut;
  wire logic [1:0] onePadOe;
  wire logic [1:0] onePadOut;

  // notes for software and integration
  // a pin meant as an input needs open-drain type and a 1 in its latch;
  // with a 0 in its latch the pad keeps pulling it low and every read shows 0.
  // port zero and port one reads show synchronised pin levels, two clocks
  // behind the pads, so a read right after a write may still see the old level.
  // the led pin reads back the intended state, never what the debug gate allows;
  // firmware that needs the real drive state must look elsewhere.
  // the input-only pin ignores its latch bit; the latch still stores it.
  // port one keeps bits 1:0 only; upper bits ignore writes and read 0.
  // bit writes are read-modify-write of the latch, not of the pin levels,
  // so a bit write never copies an externally pulled-low level into the latch.
  // bit writes to the page or drive type registers are ignored.
  // the page register drives no pad and only feeds the paged access address.
  // after reset every pin is open-drain, so nothing is driven high.
  // the led pin stays open-drain whatever its drive type bit says.
  // open-drain pins on port one keep their pull-up; push-pull drops it.
  // port zero pads rely on their own pull-ups outside this block.
  // a byte write and a bit write in one cycle to a port latch: the bit write wins.
  // reads are combinational from the address, no read strobe is needed.
  // nothing here changes state on a read, so repeated reads are harmless.

  // merge a single-bit write into a byte
  function automatic logic [7:0] setBit(input logic [7:0] cur, input logic [2:0] idx,
                                        input logic val);
    logic [7:0] res;
    res      = cur;
    res[idx] = val;
    return res;
  endfunction

  // true when a write of either kind targets the given register
  function automatic logic hitsReg(input logic [7:0] addr, input logic [7:0] target,
                                   input logic byteWr, input logic bitWr);
    return (byteWr || bitWr) && (addr == target);
  endfunction

  // level code 00 means no led current at all
  function automatic logic levelActive(input logic [1:0] level);
    return level != gpr_pkg::LED_LEVEL_OFF;
  endfunction

  // a 0 always pulls low; a 1 drives only when the pad is push-pull
  function automatic logic padEnable(input logic latchBit, input logic pushPull);
    return !latchBit || pushPull;
  endfunction

  // write strobes; bit writes only reach the two port latches
  always_comb begin
    zeroLatchWrEn = hitsReg(regAddr, gpr_pkg::ADDR_PORT_ZERO_LATCH, regWrEn, bitWrEn);
    oneLatchWrEn  = hitsReg(regAddr, gpr_pkg::ADDR_PORT_ONE_LATCH, regWrEn, bitWrEn);
    pageWrEn      = hitsReg(regAddr, gpr_pkg::ADDR_DATA_PAGE_SELECT, regWrEn, 1'b0);
    zeroTypeWrEn  = hitsReg(regAddr, gpr_pkg::ADDR_PORT_ZERO_DRIVE_TYPE, regWrEn, 1'b0);
    oneTypeWrEn   = hitsReg(regAddr, gpr_pkg::ADDR_PORT_ONE_DRIVE_TYPE, regWrEn, 1'b0);
  end

  // byte or bit write value for port zero
  always_comb begin
    zeroWrNxt = regWrData;
    if (bitWrEn) begin
      zeroWrNxt = setBit(portZeroLatch_r, bitSel, bitVal); // [RULE_14]
    end
  end

  // byte or bit write value for port one; upper bits are dropped later
  always_comb begin
    oneWrNxt = regWrData;
    if (bitWrEn) begin
      oneWrNxt = setBit({6'h00, portOneLatch_r}, bitSel, bitVal); // [RULE_14]
    end
  end

  // two-stage synchroniser for the port zero pins
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      zeroMeta_r <= 8'h00;
      zeroSync_r <= 8'h00;
    end else begin
      zeroMeta_r <= portZeroPinIn; // [RULE_16]
      zeroSync_r <= zeroMeta_r;
    end
  end

  // two-stage synchroniser for the port one pins
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      oneMeta_r <= 2'h0;
      oneSync_r <= 2'h0;
    end else begin
      oneMeta_r <= portOnePinIn; // [RULE_16]
      oneSync_r <= oneMeta_r;
    end
  end

  // port zero data latch
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      portZeroLatch_r <= gpr_pkg::RST_PORT_ZERO_LATCH;
    end else if (zeroLatchWrEn) begin
      portZeroLatch_r <= zeroWrNxt; // [RULE_01] [RULE_14]
    end
  end

  // port one data latch, two bits kept
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      portOneLatch_r <= gpr_pkg::RST_PORT_ONE_LATCH;
    end else if (oneLatchWrEn) begin
      portOneLatch_r <= oneWrNxt[1:0]; // [RULE_09]
    end
  end

  // data page register, plain storage
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dataPageSelect_r <= gpr_pkg::RST_DATA_PAGE_SELECT;
    end else if (pageWrEn) begin
      dataPageSelect_r <= regWrData; // [RULE_12]
    end
  end

  // port zero drive type register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      portZeroDriveType_r <= gpr_pkg::RST_PORT_ZERO_DRIVE_TYPE;
    end else if (zeroTypeWrEn) begin
      portZeroDriveType_r <= regWrData; // [RULE_07]
    end
  end

  // port one drive type register, two bits kept
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      portOneDriveType_r <= gpr_pkg::RST_PORT_ONE_DRIVE_TYPE;
    end else if (oneTypeWrEn) begin
      portOneDriveType_r <= regWrData[1:0]; // [RULE_11]
    end
  end

  // port zero readback: live levels, pin 5 shows the intended led state
  always_comb begin
    zeroReadback                   = zeroSync_r; // [RULE_01] [RULE_02]
    zeroReadback[gpr_pkg::LED_BIT] = ledIntended; // [RULE_05] [RULE_06]
  end

  // port one readback, unused bits read 0
  always_comb begin
    oneReadback = {6'h00, oneSync_r}; // [RULE_09]
  end

  // drive type readback, unused port one bits read 0
  always_comb begin
    zeroTypeRd = portZeroDriveType_r;
    oneTypeRd  = {6'h00, portOneDriveType_r}; // [RULE_11]
  end

  // read data multiplexer; unmapped addresses read 0
  always_comb begin
    case (regAddr)
      gpr_pkg::ADDR_PORT_ZERO_LATCH:      regRdData = zeroReadback;
      gpr_pkg::ADDR_PORT_ONE_LATCH:       regRdData = oneReadback;
      gpr_pkg::ADDR_DATA_PAGE_SELECT:     regRdData = dataPageSelect_r;
      gpr_pkg::ADDR_PORT_ZERO_DRIVE_TYPE: regRdData = zeroTypeRd;
      gpr_pkg::ADDR_PORT_ONE_DRIVE_TYPE:  regRdData = oneTypeRd;
      default:                            regRdData = 8'h00;
    endcase
  end

  // bit test of the addressed register
  always_comb begin
    bitRdData = regRdData[bitSel]; // [RULE_14]
  end

  // led intent: data bit asks for light and a current level is chosen
  always_comb begin
    ledLevelOn  = levelActive(ledCurrentLevel); // [RULE_15]
    ledIntended = portZeroLatch_r[gpr_pkg::LED_BIT] && ledLevelOn; // [RULE_05]
  end

  // led current source, also gated by the debug override
  always_comb begin
    ledDriveEn    = ledIntended && !ledDebugOff; // [RULE_04] [RULE_06]
    ledDriveLevel = ledDriveEn ? ledCurrentLevel : gpr_pkg::LED_LEVEL_OFF; // [RULE_15]
  end

  // page byte for paged external data accesses
  always_comb begin
    pagedDataPage = dataPageSelect_r; // [RULE_13]
  end

  // port zero pads, one slice per pin
  generate
    for (genvar i = 0; i < 8; i++) begin : g_zeroPad
      if (i == gpr_pkg::INPUT_ONLY_BIT) begin : g_inputOnly
        // input-only pin: never driven, whatever its latch bit holds
        assign zeroPadOe[i]  = 1'b0; // [RULE_03]
        assign zeroPadOut[i] = 1'b0; // [RULE_03]
      end else if (i == gpr_pkg::LED_BIT) begin : g_ledPad
        // led pin: open-drain pulldown, released while the latch asks for light
        assign zeroPadOe[i]  = ~portZeroLatch_r[i]; // [RULE_04]
        assign zeroPadOut[i] = 1'b0; // [RULE_04]
      end else begin : g_plainPad
        // plain pin: drive type picks open-drain or push-pull
        assign zeroPadOe[i]  = padEnable(portZeroLatch_r[i], portZeroDriveType_r[i]); // [RULE_07]
        assign zeroPadOut[i] = portZeroLatch_r[i] & portZeroDriveType_r[i]; // [RULE_02]
      end
    end
  endgenerate

  // port one pads; open-drain pins keep their pull-up
  generate
    for (genvar j = 0; j < gpr_pkg::PORT_ONE_WIDTH; j++) begin : g_onePad
      assign onePadOe[j]  = padEnable(portOneLatch_r[j], portOneDriveType_r[j]); // [RULE_10]
      assign onePadOut[j] = portOneLatch_r[j] & portOneDriveType_r[j]; // [RULE_10]
    end
  endgenerate

  // pad outputs
  always_comb begin
    portZeroPinOe   = zeroPadOe;
    portZeroPinOut  = zeroPadOut;
    portOnePinOe    = onePadOe;
    portOnePinOut   = onePadOut;
    portOnePullUpEn = ~portOneDriveType_r; // [RULE_10]
  end

endmodule
`default_nettype wire

// file: verification/gpr_port_regs_checker.sv
// assertions on the gpio port register block ports
`timescale 1ns/100ps
`default_nettype none
module gpr_port_regs_checker (
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       regWrEn,
  input wire logic       bitWrEn,
  input wire logic       ledDebugOff,
  input wire logic       ledDriveEn,
  input wire logic [1:0] ledCurrentLevel,
  input wire logic [1:0] ledDriveLevel,
  input wire logic [1:0] portOnePinIn,
  input wire logic [1:0] portOnePinOe,
  input wire logic [1:0] portOnePinOut,
  input wire logic [1:0] portOnePullUpEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic [7:0] portZeroPinOe,
  input wire logic [7:0] portZeroPinOut,
  input wire logic [7:0] pagedDataPage
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // byte write of all zeros to port zero
  sequence zero_wr_s;
    regWrEn && !bitWrEn && regAddr == 8'h80 && regWrData == 8'h00;
  endsequence
  input_only_a: assert property (!portZeroPinOe[0]) else $error("pin 0 driven");
  zero_drive_a: assert property
    (zero_wr_s |=> portZeroPinOe == 8'hFE && !portZeroPinOut) else $error("low drive");
  led_off_a: assert property
    (!ledCurrentLevel || ledDebugOff |-> !ledDriveEn && !ledDriveLevel) else $error("led on");
  led_level_a: assert property
    (ledDriveEn |-> ledDriveLevel == ledCurrentLevel && !portZeroPinOe[5]) else $error("led");
  led_read_a: assert property
    (regAddr == 8'h80 && !ledCurrentLevel |-> !regRdData[5]) else $error("led readback");
  one_read_a: assert property
    (regAddr == 8'h90 && !$past(sys_rst) && !$past(sys_rst, 2)
     |-> regRdData == {6'h00, $past(portOnePinIn, 2)}) else $error("port one read");
  pull_up_a: assert property ((portOnePullUpEn | portOnePinOe) == 2'h3)
    else $error("pull-up");
  pull_push_a: assert property ((portOnePullUpEn & portOnePinOut) == 2'h0)
    else $error("pull-up while driving high");
  page_hold_a: assert property
    (regWrEn && !bitWrEn && regAddr == 8'hA0 |=> pagedDataPage == $past(regWrData))
    else $error("page");
endmodule
bind gpr_port_regs gpr_port_regs_checker gpr_port_regs_checker_inst (.*);
`default_nettype wire

// file: verification/gpr_pins.sv
// external pins: pull-ups and buttons to ground
`timescale 1ns/100ps
`default_nettype none
module gpr_pins #(parameter int W = 8) (
  input  wire logic [W-1:0] pinOut,
  input  wire logic [W-1:0] pinOe,
  input  wire logic [W-1:0] pullUp,
  input  wire logic [W-1:0] btnLow,
  output logic      [W-1:0] pinLvl
);
  // driver wins, then a button, then the pull-up; a floating pin inverts
  assign pinLvl = (pinOe & pinOut) | (~pinOe & ~btnLow & (pullUp | ~pinOut));
endmodule
`default_nettype wire

// file: verification/gpr_port_regs_tb.sv
// self-checking bench for the gpio port register block
`timescale 1ns/100ps
`default_nettype none
module gpr_port_regs_tb;
  logic       ref_clk = 1'h0, sys_rst = 1'h1, regWrEn = 1'h0, bitWrEn = 1'h0, bitVal = 1'h0;
  logic       ledDebugOff = 1'h0, chk = 1'h0, bitRdData, ledDriveEn;
  logic [2:0] bitSel = 3'h0;
  logic [1:0] ledCurrentLevel = 2'h0, btn1 = 2'h0, portOnePinIn, portOnePinOut, portOnePinOe;
  logic [1:0] portOnePullUpEn, ledDriveLevel;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, btn0 = 8'h00, rnd = 8'h3b, r, d, t, e;
  logic [7:0] regRdData, portZeroPinIn, portZeroPinOut, portZeroPinOe, pagedDataPage, q[$];
  int         fail_count = 0, checks = 0, cyc = 0;
  logic [15:0] rstTab[6] = '{16'hA400, 16'hA500, 16'hA000, 16'h8100, 16'h80DF, 16'h9003};
  always #5 ref_clk = ~ref_clk;
  gpr_port_regs gpr_port_regs_inst (.*);
  gpr_pins #(.W(8)) pinsZero (.pinOut(portZeroPinOut), .pinOe(portZeroPinOe), .pullUp(8'hFF),
    .btnLow(btn0), .pinLvl(portZeroPinIn));
  gpr_pins #(.W(2)) pinsOne (.pinOut(portOnePinOut), .pinOe(portOnePinOe),
    .pullUp(portOnePullUpEn), .btnLow(btn1), .pinLvl(portOnePinIn));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // one cycle at the falling edge; a read notes its expected value
  task automatic op(input logic [7:0] a, input logic [7:0] v, input logic w, input logic c);
    @(negedge ref_clk);
    regAddr = a;
    regWrData = v;
    regWrEn = w;
    chk = c;
    if (c) q.push_back(v);
  endtask
  task automatic final_report;
    $display("fail_count %0d checks %0d", fail_count, checks);
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // compares each read with the oldest note; bounds the run
  always @(posedge ref_clk) begin
    cyc++;
    if (chk) begin
      checks++;
      if (regRdData !== q[0]) begin
        fail_count++;
        $display("MISMATCH regRdData %h expected %h seen %h", regAddr, q[0], regRdData);
      end
      if (bitRdData !== q[0][bitSel]) begin
        fail_count++;
        $display("MISMATCH bitRdData expected %h seen %h", q[0][bitSel], bitRdData);
      end
      void'(q.pop_front());
    end
    if (cyc > 500) begin
      fail_count++;
      final_report();
    end
  end
  // reset values, then random drive types, latches, buttons and led levels
  initial begin
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'h0;
    foreach (rstTab[i]) op(rstTab[i][15:8], rstTab[i][7:0], 1'h0, 1'h1);
    op(8'h80, 8'h00, 1'h1, 1'h0);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(lfsr(lfsr(rnd)));
      r = rnd;
      d = lfsr(r);
      t = lfsr(d);
      {btn1, ledCurrentLevel, ledDebugOff, btn0} = {r[4:0] ^ t[4:0], d & t};
      op(8'hA4, d, 1'h1, 1'h0);
      op(8'hA5, t, 1'h1, 1'h0);
      op(8'h90, r ^ t, 1'h1, 1'h0);
      op(8'hA0, r ^ d, 1'h1, 1'h0);
      op(8'h80, r, 1'h1, 1'h0);
      op(8'h80, 8'h00, 1'h0, 1'h0);
      {bitWrEn, bitSel, bitVal} = {1'h1, t[7:5], d[7]};
      op(8'hA0, r ^ d, 1'h0, 1'h1);
      bitWrEn = 1'h0;
      r[t[7:5]] = d[7];
      e = (r & (d | ~btn0) & 8'hDE) | {2'h0, r[5] && ledCurrentLevel, 4'h0, !btn0[0]};
      op(8'hA5, {6'h00, t[1:0]}, 1'h0, 1'h1);
      op(8'h80, e, 1'h0, 1'h1);
      e = r ^ t;
      op(8'h90, {6'h00, e[1:0] & (t[1:0] | ~btn1)}, 1'h0, 1'h1);
    end
    op(8'h00, 8'h00, 1'h0, 1'h0);
    final_report();
  end
endmodule
`default_nettype wire
